// file: fps_pkg.sv
// Purpose: shared constants and types of the flash program sequencer
// Assumes: word-addressed 16-bit multiplexed bus
// Notes: command codes and unlock offsets are the device's own
package fps_pkg;
   localparam int ADDR_W = 24;
   localparam int DATA_W = 16;
   localparam int BUF_WORDS = 32;
   localparam int CNT_W = 6;
   localparam int PAGE_LSB = 5;
   localparam int SECT_LSB = 16;
   // ****************************************************************
   // command offsets and codes
   // ****************************************************************
   localparam logic [11:0] UNLOCK1_OFS = 12'h555;
   localparam logic [11:0] UNLOCK2_OFS = 12'h2aa;
   localparam logic [15:0] UNLOCK1_DAT = 16'h00aa;
   localparam logic [15:0] UNLOCK2_DAT = 16'h0055;
   localparam logic [15:0] PROG_CMD = 16'h00a0;
   localparam logic [15:0] BUF_LOAD_CMD = 16'h0025;
   localparam logic [15:0] BUF_CONFIRM_CMD = 16'h0029;
   localparam logic [15:0] SUSPEND_CMD = 16'h00b0;
   localparam logic [15:0] RESUME_CMD = 16'h0030;
   localparam logic [15:0] RESET_CMD = 16'h00f0;
   localparam logic [15:0] ERASED_WORD = 16'hffff;
   // ****************************************************************
   // timing, as cycles of the 100 MHz core clock
   // ****************************************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int WORD_PROG_NS = 400;
   localparam int WORD_PROG_CYC = (WORD_PROG_NS + CLK_PERIOD_NS - 1)
      / CLK_PERIOD_NS;
   localparam int TOGGLE_RST = 0;
   typedef enum logic [3:0] {
      FPS_IDLE, FPS_UNL1, FPS_UNL2, FPS_WDATA, FPS_BCOUNT, FPS_BLOAD,
      FPS_BCONF, FPS_BUSY, FPS_SUSP, FPS_ABORT
   } fps_state_e;
endpackage

// file: fps_buf_mem.sv
// Purpose: write buffer storage, one word per page slot
// Assumes: one write port, one registered read port
// Notes: rewriting a slot simply overwrites it
`timescale 1ns/1ps
`default_nettype none
module fps_buf_mem #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32,
   parameter int AW = 5
) (
   input wire logic core_clk,
   input wire logic clk_en,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic [AW-1:0] rd_addr,
   output logic [WIDTH-1:0] rd_data
);
   logic [WIDTH-1:0] mem [DEPTH];
   // ****************************************************************
   // storage with registered read
   // ****************************************************************
   always_ff @(posedge core_clk) begin
      if (clk_en) begin
         if (wr_en) begin
            mem[wr_addr] <= wr_data;
         end
         rd_data <= mem[rd_addr];
      end
   end
endmodule
`default_nettype wire

// file: fps_sequencer.sv
// Purpose: program-side command sequencer of a NOR flash
// Assumes: bus strobes arrive from pins, array behind a simple port
// Notes: erase itself is outside; only its suspend state is an input
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - address caught at avd rise or we fall
// - data caught at first we rise
// - finished algorithm returns to read mode
// - programming only clears bits, never sets
// - while busy only suspend is taken
// - no id, cfi, secure region while programming
// - hardware reset aborts program at once
// - single words go anywhere in any order
// - single word: aa, 55, a0, data
// - after word program report status bits
// - write buffer holds up to 32 words
// - unlock, load command, then count minus one
// - count above buffer size aborts
// - first pair lowest, rest ascending in page
// - other sector or page aborts
// - pair count mismatch ignores confirm; here an early confirm is handled as one more load
// - counter drops on each load, last wins
// - confirm at sector, anything else aborts
// - buffer status on five data bits
// - buffer program suspends, resumes, returns read
// - erase suspended still allows lock changes
// - buffer load code is 0025h
// - confirm code is 0029h
module fps_sequencer
   import fps_pkg::*;
#(
   parameter int BUF_DEPTH = fps_pkg::BUF_WORDS,
   parameter int PROG_CYCLES = fps_pkg::WORD_PROG_CYC
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic chip_enable_n,
   input wire logic address_valid_n,
   input wire logic write_enable_n,
   input wire logic output_enable_n,
   input wire logic [fps_pkg::ADDR_W-1:0] bus_addr,
   input wire logic [fps_pkg::DATA_W-1:0] bus_data_in,
   output logic [fps_pkg::DATA_W-1:0] status_data,
   output logic status_valid,
   output logic erase_suspend_active,
   input wire logic erase_suspended,
   input wire logic [fps_pkg::DATA_W-1:0] array_rd_data,
   output logic [fps_pkg::ADDR_W-1:0] array_addr,
   output logic [fps_pkg::DATA_W-1:0] array_wr_data,
   output logic array_wr_en,
   output logic busy,
   output logic buffer_aborted,
   output logic special_modes_blocked,
   output logic lock_change_allowed
);
   import fps_pkg::*;
   localparam int BAW = $clog2(BUF_DEPTH);

   // decode of a command write against an unlock offset
   function automatic logic is_cmd(input logic [ADDR_W-1:0] a,
                                   input logic [DATA_W-1:0] d,
                                   input logic [11:0] ofs,
                                   input logic [15:0] code);
      is_cmd = (a[11:0] == ofs) && (d == code);
   endfunction

   typedef struct packed {
      logic [2:0] we_sync;
      logic [2:0] avd_sync;
      logic [ADDR_W-1:0] lat_addr;
      logic addr_taken;
      fps_state_e state;
      fps_state_e resume_state;
      logic is_buffer;
      logic [ADDR_W-1:0] sect_addr;
      logic [ADDR_W-1:0] page_addr;
      logic [ADDR_W-1:0] last_addr;
      logic [CNT_W-1:0] word_count;
      logic [CNT_W-1:0] loads_left;
      logic [BAW-1:0] next_slot;
      logic first_load;
      logic [CNT_W-1:0] prog_idx;
      logic [15:0] prog_timer;
      logic [DATA_W-1:0] prog_data;
      logic [ADDR_W-1:0] prog_addr;
      logic toggle;
      logic abort_flag;
      logic [DATA_W-1:0] status;
      logic stat_valid;
      logic wr_en;
      logic [ADDR_W-1:0] wr_addr;
      logic [DATA_W-1:0] wr_data;
      logic [DATA_W-1:0] orig_bit7;
   } fps_state_s;

   fps_state_s st_reg, st_next;
   logic we_fall, we_rise, avd_rise, wr_cycle;
   logic [ADDR_W-1:0] cyc_addr;
   logic [DATA_W-1:0] cyc_data;
   logic buf_wr;
   logic [BAW-1:0] buf_waddr, buf_raddr;
   logic [DATA_W-1:0] buf_rdata;

   // ****************************************************************
   // pin edges, taken where the second and third stages differ
   // ****************************************************************
   assign we_fall = st_reg.we_sync[2] & ~st_reg.we_sync[1];
   assign we_rise = ~st_reg.we_sync[2] & st_reg.we_sync[1];
   assign avd_rise = ~st_reg.avd_sync[2] & st_reg.avd_sync[1];
   // a write ends with we rising while the chip is selected
   assign wr_cycle = we_rise & ~chip_enable_n & output_enable_n;
   assign cyc_addr = st_reg.lat_addr;
   assign cyc_data = bus_data_in;

   // ****************************************************************
   // write buffer storage
   // ****************************************************************
   fps_buf_mem #(
      .WIDTH(DATA_W),
      .DEPTH(BUF_DEPTH),
      .AW(BAW)
   ) u_buf (
      .core_clk(core_clk),
      .clk_en(clk_en),
      .wr_en(buf_wr),
      .wr_addr(buf_waddr),
      .wr_data(cyc_data),
      .rd_addr(buf_raddr),
      .rd_data(buf_rdata)
   );

   // ****************************************************************
   // next-state logic for the whole sequencer
   // ****************************************************************
   always_comb begin
      st_next = st_reg;
      buf_wr = 1'b0;
      buf_waddr = cyc_addr[BAW-1:0];
      buf_raddr = st_reg.page_addr[BAW-1:0] + st_reg.prog_idx[BAW-1:0];
      st_next.we_sync = {st_reg.we_sync[1:0], write_enable_n};
      st_next.avd_sync = {st_reg.avd_sync[1:0], address_valid_n};
      st_next.wr_en = 1'b0;
      // address latch: avd rise or we fall, once per write cycle
      if (avd_rise && !chip_enable_n) begin
         st_next.lat_addr = bus_addr;
         st_next.addr_taken = 1'b1;
      end else if (we_fall && !st_reg.addr_taken) begin
         st_next.lat_addr = bus_addr;
      end
      if (we_rise) begin
         st_next.addr_taken = 1'b0;
      end
      case (st_reg.state)
         FPS_IDLE, FPS_ABORT: begin
            if (wr_cycle) begin
               if (is_cmd(cyc_addr, cyc_data, UNLOCK1_OFS, UNLOCK1_DAT)) begin
                  st_next.state = FPS_UNL1;
               end else if (cyc_data == RESET_CMD) begin
                  st_next.state = FPS_IDLE;
                  st_next.abort_flag = 1'b0;
                  st_next.stat_valid = 1'b0;
               end
            end
         end
         FPS_UNL1: begin
            if (wr_cycle) begin
               st_next.state =
                  is_cmd(cyc_addr, cyc_data, UNLOCK2_OFS, UNLOCK2_DAT) ?
                  FPS_UNL2 : FPS_IDLE;
            end
         end
         FPS_UNL2: begin
            if (wr_cycle) begin
               st_next.state = FPS_IDLE;
               if (is_cmd(cyc_addr, cyc_data, UNLOCK1_OFS, PROG_CMD)) begin
                  st_next.state = FPS_WDATA;
               end else if (cyc_data == BUF_LOAD_CMD) begin
                  st_next.state = FPS_BCOUNT;
                  st_next.sect_addr = cyc_addr;
               end else if (cyc_data == RESET_CMD) begin
                  st_next.abort_flag = 1'b0;
                  st_next.stat_valid = 1'b0;
               end
            end
         end
         FPS_WDATA: begin
            // any address, any sector, any order
            if (wr_cycle) begin
               st_next.is_buffer = 1'b0;
               st_next.prog_addr = cyc_addr;
               st_next.prog_data = cyc_data;
               st_next.last_addr = cyc_addr;
               st_next.word_count = '0;
               st_next.prog_idx = '0;
               st_next.prog_timer = 16'(PROG_CYCLES);
               st_next.stat_valid = 1'b1;
               st_next.status = '0;
               st_next.orig_bit7 = cyc_data;
               st_next.state = FPS_BUSY;
            end
         end
         FPS_BCOUNT: begin
            if (wr_cycle) begin
               if (cyc_addr[ADDR_W-1:SECT_LSB] !=
                   st_reg.sect_addr[ADDR_W-1:SECT_LSB]) begin
                  st_next.state = FPS_ABORT;
               end else if (cyc_data >= DATA_W'(BUF_DEPTH)) begin
                  // polling bit is forced to zero here by the abort flag
                  st_next.state = FPS_ABORT;
                  st_next.abort_flag = 1'b1;
                  st_next.stat_valid = 1'b1;
                  st_next.status = '0;
                  st_next.status[1] = 1'b1;
               end else begin
                  st_next.word_count = CNT_W'(cyc_data[4:0]);
                  st_next.loads_left = CNT_W'(cyc_data[4:0]) + 1'b1;
                  st_next.first_load = 1'b1;
                  st_next.state = FPS_BLOAD;
               end
            end
         end
         FPS_BLOAD: begin
            if (wr_cycle) begin
               if (cyc_addr[ADDR_W-1:SECT_LSB] !=
                   st_reg.sect_addr[ADDR_W-1:SECT_LSB]) begin
                  st_next.state = FPS_ABORT;
               end else if (!st_reg.first_load &&
                  cyc_addr[ADDR_W-1:PAGE_LSB] !=
                  st_reg.page_addr[ADDR_W-1:PAGE_LSB]) begin
                  st_next.state = FPS_ABORT;
               end else if (!st_reg.first_load &&
                  cyc_addr[BAW-1:0] < st_reg.page_addr[BAW-1:0]) begin
                  // below the starting address breaks ascending order
                  st_next.state = FPS_ABORT;
               end else begin
                  buf_wr = 1'b1;
                  if (st_reg.first_load) begin
                     st_next.page_addr = cyc_addr;
                  end
                  st_next.first_load = 1'b0;
                  st_next.last_addr = cyc_addr;
                  st_next.loads_left = st_reg.loads_left - 1'b1;
                  if (st_reg.loads_left == CNT_W'(1)) begin
                     st_next.state = FPS_BCONF;
                  end
               end
               if (st_next.state == FPS_ABORT) begin
                  st_next.abort_flag = 1'b1;
                  st_next.stat_valid = 1'b1;
                  st_next.status = '0;
                  st_next.status[1] = 1'b1;
               end
            end
         end
         FPS_BCONF: begin
            if (wr_cycle) begin
               if (cyc_data == BUF_CONFIRM_CMD && st_reg.loads_left == '0 &&
                   cyc_addr[ADDR_W-1:SECT_LSB] ==
                   st_reg.sect_addr[ADDR_W-1:SECT_LSB]) begin
                  st_next.is_buffer = 1'b1;
                  st_next.prog_idx = '0;
                  st_next.prog_addr = st_reg.page_addr;
                  st_next.prog_timer = 16'(PROG_CYCLES);
                  st_next.stat_valid = 1'b1;
                  st_next.status = '0;
                  st_next.state = FPS_BUSY;
               end else begin
                  st_next.state = FPS_ABORT;
                  st_next.abort_flag = 1'b1;
                  st_next.stat_valid = 1'b1;
                  st_next.status = '0;
                  st_next.status[1] = 1'b1;
               end
            end
         end
         FPS_BUSY: begin
            // only suspend is honoured, everything else dropped
            if (wr_cycle && cyc_data == SUSPEND_CMD) begin
               st_next.state = FPS_SUSP;
            end else if (st_reg.prog_timer != '0) begin
               st_next.prog_timer = st_reg.prog_timer - 1'b1;
               st_next.toggle = ~st_reg.toggle;
            end else begin
               st_next.wr_en = 1'b1;
               st_next.wr_addr = st_reg.is_buffer ?
                  {st_reg.page_addr[ADDR_W-1:BAW], buf_raddr} :
                  st_reg.prog_addr;
               // one-to-zero only: and with what is stored
               st_next.wr_data = array_rd_data &
                  (st_reg.is_buffer ? buf_rdata : st_reg.prog_data);
               // stop at the slot of the last load
               if (!st_reg.is_buffer ||
                   buf_raddr == st_reg.last_addr[BAW-1:0]) begin
                  st_next.state = FPS_IDLE;
                  st_next.stat_valid = 1'b0;
               end else begin
                  st_next.prog_idx = st_reg.prog_idx + 1'b1;
                  st_next.prog_timer = 16'(PROG_CYCLES);
               end
            end
         end
         FPS_SUSP: begin
            if (wr_cycle && cyc_data == RESUME_CMD) begin
               st_next.state = FPS_BUSY;
            end
         end
         default: begin
            st_next.state = FPS_IDLE;
         end
      endcase
      // status word: polling bit inverted, toggle, abort bit
      if (st_next.stat_valid) begin
         st_next.status[7] = st_next.abort_flag ? 1'b0 :
            ~st_next.orig_bit7[7];
         st_next.status[6] = st_next.toggle;
         st_next.status[2] = st_next.toggle;
         st_next.status[5] = 1'b0;
         st_next.status[1] = st_next.abort_flag;
      end
   end

   // ****************************************************************
   // state register; reset drops any running program at once
   // ****************************************************************
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '{we_sync: 3'h7, avd_sync: 3'h7, state: FPS_IDLE,
            resume_state: FPS_IDLE, default: '0};
      end else if (clk_en) begin
         st_reg <= st_next;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign busy = (st_reg.state == FPS_BUSY);
   // id, cfi and secure region stay closed while a program runs
   assign special_modes_blocked = (st_reg.state == FPS_BUSY) ||
      (st_reg.state == FPS_SUSP);
   assign lock_change_allowed = erase_suspended ||
      (st_reg.state == FPS_IDLE);
   assign erase_suspend_active = erase_suspended;
   assign buffer_aborted = st_reg.abort_flag;
   assign status_data = st_reg.status;
   assign status_valid = st_reg.stat_valid;
   // the write pulse shows its own address, not the next target
   assign array_addr = (busy && !st_reg.wr_en) ? (st_reg.is_buffer ?
      {st_reg.page_addr[ADDR_W-1:BAW], buf_raddr} :
      st_reg.prog_addr) : st_reg.wr_addr;
   assign array_wr_data = st_reg.wr_data;
   assign array_wr_en = st_reg.wr_en;
endmodule
`default_nettype wire

// file: fps_seq_sva.sv
// Purpose: port checks of the flash program sequencer
// Assumes: one clock domain, reset async and active low
// Notes: program time handed on from the design's parameter
`timescale 1ns/1ps
`default_nettype none
module fps_seq_sva
   import fps_pkg::*;
#(
   parameter int PROG_CYCLES = 4
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic erase_suspended,
   input wire logic [fps_pkg::DATA_W-1:0] array_rd_data,
   input wire logic [fps_pkg::DATA_W-1:0] array_wr_data,
   input wire logic array_wr_en,
   input wire logic [fps_pkg::DATA_W-1:0] status_data,
   input wire logic status_valid,
   input wire logic busy,
   input wire logic buffer_aborted,
   input wire logic special_modes_blocked,
   input wire logic lock_change_allowed
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // ****************************************************************
   // properties
   // ****************************************************************
   // an array write may clear bits but never raise one
   property p_only_clear;
      array_wr_en |-> (array_wr_data & ~array_rd_data) == '0;
   endproperty
   a_only_clear: assert property (p_only_clear)
      else $error("array write raised a bit");
   property p_modes;
      busy |-> special_modes_blocked;
   endproperty
   a_modes: assert property (p_modes)
      else $error("special modes open while busy");
   // lock changes stay open for a held erase suspend
   property p_lock;
      erase_suspended [*2] |-> lock_change_allowed;
   endproperty
   a_lock: assert property (p_lock)
      else $error("lock change refused in erase suspend");
   // last array write ends the status report
   property p_done_idle;
      array_wr_en ##1 !busy |-> !status_valid;
   endproperty
   a_done_idle: assert property (p_done_idle)
      else $error("status still valid after completion");
   // no array write right at the start of the program time
   property p_early;
      $rose(busy) && !$past(special_modes_blocked) |-> !array_wr_en [*8];
   endproperty
   a_early: assert property (p_early)
      else $error("array written too early");
   property p_abort_idle;
      buffer_aborted |-> !busy && !array_wr_en;
   endproperty
   a_abort_idle: assert property (p_abort_idle)
      else $error("aborted buffer still programming");
   property p_abort_bit;
      buffer_aborted |-> status_data[1];
   endproperty
   a_abort_bit: assert property (p_abort_bit)
      else $error("abort bit missing in status");
   property p_rst;
      $rose(rst_n) |-> !busy && !array_wr_en;
   endproperty
   a_rst: assert property (p_rst)
      else $error("program survived reset");
   c_busy: cover property ($rose(busy));
   c_abort: cover property ($rose(buffer_aborted));
   c_write: cover property (array_wr_en);
endmodule
bind fps_sequencer fps_seq_sva #(.PROG_CYCLES(PROG_CYCLES)) i_fps_seq_sva (
   .core_clk(core_clk), .rst_n(rst_n), .erase_suspended(erase_suspended),
   .array_rd_data(array_rd_data), .array_wr_data(array_wr_data),
   .array_wr_en(array_wr_en), .status_data(status_data),
   .status_valid(status_valid), .busy(busy),
   .buffer_aborted(buffer_aborted),
   .special_modes_blocked(special_modes_blocked),
   .lock_change_allowed(lock_change_allowed)
);
`default_nettype wire

// file: fps_host_model.sv
// Purpose: host controller on the multiplexed flash bus
// Assumes: strobes move on the falling clock edge
// Notes: a released bus shows the inverse of its last value
`timescale 1ns/1ps
`default_nettype none
module fps_host_model (
   input wire logic core_clk,
   output logic chip_enable_n,
   output logic address_valid_n,
   output logic write_enable_n,
   output logic output_enable_n,
   output logic [fps_pkg::ADDR_W-1:0] bus_addr,
   output logic [fps_pkg::DATA_W-1:0] bus_data_in
);
   import fps_pkg::*;
   // idle bus at time zero, nothing selected
   initial begin
      chip_enable_n = 1'b1;
      address_valid_n = 1'b1;
      write_enable_n = 1'b1;
      output_enable_n = 1'b1;
      bus_addr = '0;
      bus_data_in = '0;
   end
   // one write: address phase, then data phase, oe kept high
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(negedge core_clk);
      chip_enable_n = 1'b0;
      address_valid_n = 1'b0;
      bus_addr = a;
      @(negedge core_clk);
      address_valid_n = 1'b1;
      @(negedge core_clk);
      write_enable_n = 1'b0;
      bus_data_in = d;
      repeat (2) @(negedge core_clk);
      write_enable_n = 1'b1;
      // data held past the synchroniser before release
      repeat (3) @(negedge core_clk);
      chip_enable_n = 1'b1;
      bus_data_in = ~d;
      bus_addr = ~a;
      repeat (2) @(negedge core_clk);
   endtask
endmodule
`default_nettype wire

// file: tb.sv
// Purpose: self-checking bench of the program sequencer
// Assumes: host model drives the bus, array is a small memory
// Notes: program time cut to 24 cycles to keep the run short
`timescale 1ns/1ps
`default_nettype none
module tb;
   import fps_pkg::*;
   localparam int PROG = 24;
   logic core_clk, rst_n, erase_suspended, status_valid, busy;
   logic chip_enable_n, address_valid_n, write_enable_n, output_enable_n;
   logic erase_suspend_active, array_wr_en, buffer_aborted;
   logic special_modes_blocked, lock_change_allowed;
   logic [ADDR_W-1:0] bus_addr, array_addr;
   logic [DATA_W-1:0] bus_data_in, status_data, array_wr_data, array_rd_data;
   logic [DATA_W-1:0] mem [0:63];
   int miscompares = 0;
   int checked = 0;
   int cyc = 0;
   int wr_cnt = 0;
   time t_busy;
   fps_sequencer #(.PROG_CYCLES(PROG)) i_fps_sequencer (
      .core_clk(core_clk), .rst_n(rst_n), .clk_en(1'b1),
      .chip_enable_n(chip_enable_n), .address_valid_n(address_valid_n),
      .write_enable_n(write_enable_n), .output_enable_n(output_enable_n),
      .bus_addr(bus_addr), .bus_data_in(bus_data_in),
      .status_data(status_data), .status_valid(status_valid),
      .erase_suspend_active(erase_suspend_active),
      .erase_suspended(erase_suspended), .array_rd_data(array_rd_data),
      .array_addr(array_addr), .array_wr_data(array_wr_data),
      .array_wr_en(array_wr_en), .busy(busy),
      .buffer_aborted(buffer_aborted),
      .special_modes_blocked(special_modes_blocked),
      .lock_change_allowed(lock_change_allowed));
   fps_host_model i_fps_host_model (
      .core_clk(core_clk), .chip_enable_n(chip_enable_n),
      .address_valid_n(address_valid_n), .write_enable_n(write_enable_n),
      .output_enable_n(output_enable_n), .bus_addr(bus_addr),
      .bus_data_in(bus_data_in));
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // array model; also counts writes and cuts a hang short
   assign array_rd_data = mem[array_addr[5:0]];
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (array_wr_en) begin
         mem[array_addr[5:0]] <= array_wr_data;
         wr_cnt <= wr_cnt + 1;
      end
      if (cyc == 5000) begin
         miscompares++;
         test_done();
      end
   end
   always @(posedge busy) t_busy = $time;
   // ****************************************************************
   // shared tasks
   // ****************************************************************
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task w(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      i_fps_host_model.wr(a, d);
   endtask
   task unl();
      w({12'h000, UNLOCK1_OFS}, UNLOCK1_DAT);
      w({12'h000, UNLOCK2_OFS}, UNLOCK2_DAT);
   endtask
   task edge1();
      @(posedge core_clk);
      #1;
   endtask
   // bounded wait for the next array write pulse
   task wait_wr();
      int n;
      n = 0;
      while (array_wr_en !== 1'b1 && n < 300) begin
         edge1();
         n++;
      end
      if (n == 300) chk(32'h0, 32'h1);
   endtask
   task test_done();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // ****************************************************************
   // scenarios
   // ****************************************************************
   task test_word();
      wr_cnt = 0;
      unl();
      w({12'h000, UNLOCK1_OFS}, PROG_CMD);
      w(24'h000003, 16'h00ff);
      chk(busy, 1);
      chk(status_valid, 1);
      chk(status_data[7], 0);
      chk(special_modes_blocked, 1);
      w({12'h000, UNLOCK1_OFS}, UNLOCK1_DAT);
      wait_wr();
      chk(32'((($time - 1) - t_busy) / 10), PROG + 1);
      chk(array_wr_data, 16'h000f);
      chk(array_addr, 24'h000003);
      edge1();
      edge1();
      chk(busy, 0);
      chk(status_valid, 0);
      // completes the dropped unlock if it had been taken
      w({12'h000, UNLOCK2_OFS}, UNLOCK2_DAT);
      w({12'h000, UNLOCK1_OFS}, PROG_CMD);
      w(24'h000006, 16'h0000);
      repeat (40) edge1();
      chk(wr_cnt, 1);
      $display("test word done");
   endtask
   task test_buf();
      wr_cnt = 0;
      unl();
      w(24'h010000, BUF_LOAD_CMD);
      w(24'h010000, 16'h0002);
      w(24'h010004, 16'h1234);
      w(24'h010005, 16'h00ff);
      w(24'h010005, 16'h5678);
      chk(busy, 0);
      w(24'h010000, BUF_CONFIRM_CMD);
      chk(busy, 1);
      wait_wr();
      chk(array_addr, 24'h010004);
      chk(array_wr_data, 16'h1234);
      edge1();
      wait_wr();
      chk(array_wr_data, 16'h5678);
      repeat (3) edge1();
      chk(busy, 0);
      chk(wr_cnt, 2);
      $display("test buffer done");
   endtask
   // count too big, other sector, no confirm, other page
   task test_abort();
      logic [15:0] cnt [4];
      logic [23:0] ld1 [4];
      logic [23:0] ld2 [4];
      cnt = '{16'h0020, 16'h0000, 16'h0000, 16'h0001};
      ld1 = '{24'h0, 24'h020004, 24'h010004, 24'h010004};
      ld2 = '{24'h0, 24'h0, 24'h010004, 24'h010024};
      for (int i = 0; i < 4; i++) begin
         unl();
         w(24'h010000, BUF_LOAD_CMD);
         w(24'h010000, cnt[i]);
         if (ld1[i] != 0) w(ld1[i], 16'h00aa);
         if (ld2[i] != 0) w(ld2[i], 16'h00aa);
         chk(buffer_aborted, 1);
         chk(status_data[1], 1);
         chk(busy, 0);
         w(24'h000000, RESET_CMD);
         chk(buffer_aborted, 0);
      end
      $display("test abort done");
   endtask
   task test_susp();
      wr_cnt = 0;
      unl();
      w(24'h010000, BUF_LOAD_CMD);
      w(24'h010000, 16'h0000);
      w(24'h010008, 16'h0f00);
      w(24'h010000, BUF_CONFIRM_CMD);
      w(24'h010000, SUSPEND_CMD);
      repeat (40) edge1();
      chk(wr_cnt, 0);
      w(24'h010000, RESUME_CMD);
      wait_wr();
      chk(array_wr_data, 16'h0f00);
      repeat (3) edge1();
      chk(busy, 0);
      $display("test suspend done");
   endtask
   task test_rst();
      wr_cnt = 0;
      unl();
      w({12'h000, UNLOCK1_OFS}, PROG_CMD);
      w(24'h7f0007, 16'h0000);
      chk(busy, 1);
      rst_n = 1'b0;
      @(negedge core_clk);
      rst_n = 1'b1;
      chk(busy, 0);
      repeat (40) edge1();
      chk(wr_cnt, 0);
      chk(mem[7], 16'hffff);
      @(negedge core_clk);
      erase_suspended = 1'b1;
      repeat (3) edge1();
      chk(lock_change_allowed, 1);
      chk(erase_suspend_active, 1);
      @(negedge core_clk);
      erase_suspended = 1'b0;
      $display("test reset done");
   endtask
   // reset held four cycles, then synchroniser settling
   initial begin
      rst_n = 1'b0;
      erase_suspended = 1'b0;
      for (int i = 0; i < 64; i++) mem[i] = 16'hffff;
      mem[3] = 16'h0f0f;
      repeat (4) @(negedge core_clk);
      rst_n = 1'b1;
      repeat (3) @(negedge core_clk);
      test_word();
      test_buf();
      test_abort();
      test_susp();
      test_rst();
      test_done();
   end
endmodule
`default_nettype wire
